// file: src/fsm_pkg.sv
// Constants for the fan stall monitor: register addresses, bit positions, timing.
// Assumes a 100 MHz system clock.
package fsm_pkg;
  localparam logic [11:0] REG_A_ADDR = 12'hc94;
  localparam logic [11:0] REG_B_ADDR = 12'hca4;
  localparam int ENABLE_BIT = 0;
  localparam int STATUS_BIT = 7;
  localparam logic [7:0] STATUS_MASK = 8'h80;
  localparam logic [7:0] ENABLE_MASK = 8'h01;
  localparam logic ENABLE_RST = 1'b0;
  localparam logic STATUS_RST = 1'b0;
  localparam int IRQ_LINE = 7;
  localparam int CLK_HZ = 100000000;
  localparam int MIN_RATE_HZ = 1;
  localparam int WINDOW_CYCLES = CLK_HZ / MIN_RATE_HZ;
endpackage : fsm_pkg

// file: src/fsm_window.sv
// One fan channel: edge detect on the tachometer and a one-second no-edge window.
// Assumes the tachometer input is already synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module fsm_window #(
  parameter int WINDOW = fsm_pkg::WINDOW_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Tachometer
  input wire logic tach_i,
  // Result
  output logic stall_o
);
  logic tach_d_r;
  logic [31:0] cnt_r;
  logic edge_seen;

  assign edge_seen = tach_i & ~tach_d_r;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      tach_d_r <= 1'b0;
    else
      tach_d_r <= tach_i;
  end

  // A rising edge restarts the window; reaching the end means below 1 Hz
  always_ff @(posedge clk_i)
  begin
    if (srst_i || edge_seen)
      cnt_r <= 32'h0;
    else if (cnt_r != 32'(WINDOW - 1))
      cnt_r <= cnt_r + 32'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      stall_o <= 1'b0;
    else
      stall_o <= !edge_seen && (cnt_r == 32'(WINDOW - 1));
  end
endmodule : fsm_window
`default_nettype wire

// file: src/fsm_monitor.sv
// Fan stall monitor with two control registers reached through 8-bit host I/O ports.
// Assumes single-cycle I/O strobes and a tachometer input synchronous to clk_i.
// How it works
// - A fan whose tachometer runs slower than 1 Hz is flagged and, when enabled, raises an interrupt.
// - Bit 0 of each control register enables the stall interrupt output.
// - Bit 7 of each control register reads one once the fan has been slow, and stays one until cleared.
// - Writing one to bit 7 clears the latched stall status.
// - If the fan is still stalled at a clear, the status stays set and the interrupt stays on while enabled.
// - Two register instances sit at I/O addresses c94 and ca4, each with its own enable and status.
// - The combined stall interrupt drives host interrupt line 7.
`timescale 1ns/1ps
`default_nettype none
module fsm_monitor #(
  parameter int WINDOW = fsm_pkg::WINDOW_CYCLES,
  parameter int NFAN = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Host I/O port access
  input wire logic [11:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  // Fan tachometers
  input wire logic [NFAN-1:0] tach_i,
  // Interrupt line 7 request
  output logic irq7_o
);
  logic [NFAN-1:0] en_r;
  logic [NFAN-1:0] stat_r;
  logic [NFAN-1:0] stall;
  logic [NFAN-1:0] sel;

  assign sel[0] = io_addr_i == fsm_pkg::REG_A_ADDR;
  assign sel[1] = io_addr_i == fsm_pkg::REG_B_ADDR;

  genvar g;
  generate
    for (g = 0; g < NFAN; g++)
    begin : g_fan
      fsm_window #(.WINDOW(WINDOW)) u_win (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .tach_i(tach_i[g]),
        .stall_o(stall[g])
      );

      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          en_r[g] <= fsm_pkg::ENABLE_RST;
        else if (io_wr_i && sel[g])
          en_r[g] <= io_wdata_i[fsm_pkg::ENABLE_BIT];
      end

      // Set wins over a same-cycle clear so a stall is never lost
      always_ff @(posedge clk_i)
      begin
        if (srst_i)
          stat_r[g] <= fsm_pkg::STATUS_RST;
        else if (stall[g])
          stat_r[g] <= 1'b1;
        else if (io_wr_i && sel[g] && io_wdata_i[fsm_pkg::STATUS_BIT])
          stat_r[g] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      io_rdata_o <= 8'h00;
    else if (io_rd_i && sel[0])
      io_rdata_o <= {stat_r[0], 6'h00, en_r[0]};
    else if (io_rd_i && sel[1])
      io_rdata_o <= {stat_r[1], 6'h00, en_r[1]};
    else
      io_rdata_o <= 8'h00;
  end

  // Level interrupt, held while any channel has status and enable
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      irq7_o <= 1'b0;
    else
      irq7_o <= |(stat_r & en_r);
  end

  property p_irq_follows;
    @(posedge clk_i) disable iff (srst_i)
    ##1 irq7_o == |($past(stat_r) & $past(en_r));
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq not tied to status and enable");

  property p_irq_gated;
    @(posedge clk_i) disable iff (srst_i)
    (en_r == '0) |=> !irq7_o;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq with enables off");

  property p_stall_sets;
    @(posedge clk_i) disable iff (srst_i)
    stall[0] |=> stat_r[0];
  endproperty
  a_stall_sets: assert property (p_stall_sets) else $error("stall did not set status");

  property p_clear;
    @(posedge clk_i) disable iff (srst_i)
    (io_wr_i && sel[0] && io_wdata_i[fsm_pkg::STATUS_BIT] && !stall[0]) |=> !stat_r[0];
  endproperty
  a_clear: assert property (p_clear) else $error("write one did not clear status");

  property p_reraise;
    @(posedge clk_i) disable iff (srst_i)
    (stall[1] && io_wr_i && sel[1] && io_wdata_i[fsm_pkg::STATUS_BIT]) |=> stat_r[1];
  endproperty
  a_reraise: assert property (p_reraise) else $error("clear beat a stall");

  property p_read;
    @(posedge clk_i) disable iff (srst_i)
    (io_rd_i && sel[0]) |=> io_rdata_o == {$past(stat_r[0]), 6'h00, $past(en_r[0])};
  endproperty
  a_read: assert property (p_read) else $error("bad read data");

  property p_enable_write;
    @(posedge clk_i) disable iff (srst_i)
    (io_wr_i && sel[1]) |=> en_r[1] == $past(io_wdata_i[fsm_pkg::ENABLE_BIT]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not stored");

  property p_sticky;
    @(posedge clk_i) disable iff (srst_i)
    (stat_r[0] && !(io_wr_i && sel[0])) |=> stat_r[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status dropped on its own");

  property p_enable_write_a;
    @(posedge clk_i) disable iff (srst_i)
    (io_wr_i && sel[0]) |=> en_r[0] == $past(io_wdata_i[fsm_pkg::ENABLE_BIT]);
  endproperty
  a_enable_write_a: assert property (p_enable_write_a) else $error("enable a not stored");

  property p_read_b;
    @(posedge clk_i) disable iff (srst_i)
    (io_rd_i && sel[1]) |=> io_rdata_o == {$past(stat_r[1]), 6'h00, $past(en_r[1])};
  endproperty
  a_read_b: assert property (p_read_b) else $error("bad read data on b");

  // Unmapped ports read as zero so a stray probe never sees a status
  property p_read_unmapped;
    @(posedge clk_i) disable iff (srst_i)
    (io_rd_i && (sel == '0)) |=> io_rdata_o == 8'h00;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped port returned data");

  property p_read_idle;
    @(posedge clk_i) disable iff (srst_i)
    !io_rd_i |=> io_rdata_o == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data without a read");

  // No disable here: this one watches the reset itself
  property p_reset_quiet;
    @(posedge clk_i)
    srst_i |=> (!irq7_o && (io_rdata_o == 8'h00) && (stat_r == '0) && (en_r == '0));
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("state not cleared by reset");

  property p_stall_sets_b;
    @(posedge clk_i) disable iff (srst_i)
    stall[1] |=> stat_r[1];
  endproperty
  a_stall_sets_b: assert property (p_stall_sets_b) else $error("stall b did not set status");

  property p_clear_b;
    @(posedge clk_i) disable iff (srst_i)
    (io_wr_i && sel[1] && io_wdata_i[fsm_pkg::STATUS_BIT] && !stall[1]) |=> !stat_r[1];
  endproperty
  a_clear_b: assert property (p_clear_b) else $error("write one did not clear status b");

  property p_sticky_b;
    @(posedge clk_i) disable iff (srst_i)
    (stat_r[1] && !(io_wr_i && sel[1])) |=> stat_r[1];
  endproperty
  a_sticky_b: assert property (p_sticky_b) else $error("status b dropped on its own");

  property p_irq_holds;
    @(posedge clk_i) disable iff (srst_i)
    ((stat_r[0] && en_r[0]) || (stat_r[1] && en_r[1])) |=> irq7_o;
  endproperty
  a_irq_holds: assert property (p_irq_holds) else $error("irq dropped while status and enable set");

  // A stall with its enable left on reaches the line in two steps: status, then request
  sequence s_stall_armed_a;
    stall[0] && en_r[0] && !(io_wr_i && sel[0]);
  endsequence

  sequence s_status_then_irq_a;
    stat_r[0] ##1 irq7_o;
  endsequence

  property p_stall_to_irq_a;
    @(posedge clk_i) disable iff (srst_i)
    s_stall_armed_a |=> s_status_then_irq_a;
  endproperty
  a_stall_to_irq_a: assert property (p_stall_to_irq_a) else $error("stall a did not reach irq");

  sequence s_stall_armed_b;
    stall[1] && en_r[1] && !(io_wr_i && sel[1]);
  endsequence

  sequence s_status_then_irq_b;
    stat_r[1] ##1 irq7_o;
  endsequence

  property p_stall_to_irq_b;
    @(posedge clk_i) disable iff (srst_i)
    s_stall_armed_b |=> s_status_then_irq_b;
  endproperty
  a_stall_to_irq_b: assert property (p_stall_to_irq_b) else $error("stall b did not reach irq");

  // A clear that keeps the enable must not silence a fan that is still stalled
  sequence s_clear_while_stalled_b;
    stall[1] && io_wr_i && sel[1] && io_wdata_i[fsm_pkg::STATUS_BIT] && io_wdata_i[fsm_pkg::ENABLE_BIT];
  endsequence

  property p_reraise_irq;
    @(posedge clk_i) disable iff (srst_i)
    s_clear_while_stalled_b |=> s_status_then_irq_b;
  endproperty
  a_reraise_irq: assert property (p_reraise_irq) else $error("clear silenced a stalled fan");
endmodule : fsm_monitor
`default_nettype wire

// file: test/fsm_tach_model.sv
// Fan tachometer stand-in: a square wave while running.
// Assumes clk_i is the monitor's own clock.
`timescale 1ns/1ps
`default_nettype none
module fsm_tach_model (
  // Clock and control
  input wire logic clk_i,
  input wire logic run_i,
  // Tachometer
  output logic tach_o
);
  logic [1:0] cnt_r = 2'h0;
  // A stalled fan leaves its line at rest, as a real rotor does
  always_ff @(posedge clk_i)
  begin
    if (run_i)
      cnt_r <= cnt_r + 2'h1;
  end
  assign tach_o = cnt_r[1];
endmodule : fsm_tach_model
`default_nettype wire

// file: test/test_fan_stall_monitor.sv
// Self-checking bench for the fan stall monitor.
// Assumes a short stall window so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module test_fan_stall_monitor;
  localparam logic [11:0] RA = 12'hc94;
  localparam logic [11:0] RB = 12'hca4;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [11:0] io_addr_i = 12'h000;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic [7:0] io_rdata_o;
  wire logic [1:0] tach_i;
  logic [1:0] run = 2'h3;
  logic irq7_o;
  int n_fail = 0;
  int samples_checked = 0;
  fsm_monitor #(.WINDOW(20), .NFAN(2)) DUT (.clk_i(clk_i), .srst_i(srst_i), .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .tach_i(tach_i), .irq7_o(irq7_o));
  fsm_tach_model fan_a (.clk_i(clk_i), .run_i(run[0]), .tach_o(tach_i[0]));
  fsm_tach_model fan_b (.clk_i(clk_i), .run_i(run[1]), .tach_o(tach_i[1]));
  initial forever #5 clk_i = ~clk_i;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic waitn(input int n);
    repeat (n) @(negedge clk_i);
  endtask : waitn
  task automatic io(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_i);
    io_addr_i = a;
    io_wdata_i = d;
    io_wr_i = wr;
    io_rd_i = ~wr;
    @(negedge clk_i);
    io_wr_i = 1'b0;
    io_rd_i = 1'b0;
  endtask : io
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    io(1'b0, a, 8'h00);
    chk("rdata", exp, io_rdata_o);
  endtask : rd
  task automatic irq(input logic exp);
    chk("irq7", {7'h00, exp}, {7'h00, irq7_o});
  endtask : irq
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic t_idle;
    rd(RA, 8'h00);
    rd(RB, 8'h00);
    rd(12'hc95, 8'h00);
    waitn(30);
    rd(RA, 8'h00);
    irq(1'b0);
    $display("idle done");
  endtask : t_idle
  task automatic t_stall;
    run[0] = 1'b0;
    waitn(30);
    rd(RA, 8'h80);
    irq(1'b0);
    io(1'b1, RA, 8'h01);
    waitn(2);
    irq(1'b1);
    rd(RA, 8'h81);
    $display("stall done");
  endtask : t_stall
  task automatic t_clear;
    io(1'b1, RA, 8'h81);
    waitn(2);
    rd(RA, 8'h81);
    irq(1'b1);
    run[0] = 1'b1;
    waitn(6);
    io(1'b1, RA, 8'h01);
    rd(RA, 8'h81);
    io(1'b1, RA, 8'h81);
    rd(RA, 8'h01);
    irq(1'b0);
    $display("clear done");
  endtask : t_clear
  task automatic t_fan_b;
    run[1] = 1'b0;
    waitn(30);
    rd(RB, 8'h80);
    rd(RA, 8'h01);
    irq(1'b0);
    io(1'b1, RB, 8'h01);
    waitn(2);
    irq(1'b1);
    io(1'b1, RB, 8'h81);
    waitn(2);
    rd(RB, 8'h81);
    irq(1'b1);
    run[1] = 1'b1;
    waitn(6);
    io(1'b1, RB, 8'h81);
    rd(RB, 8'h01);
    irq(1'b0);
    $display("fan b done");
  endtask : t_fan_b
  task automatic t_reset;
    run[0] = 1'b0;
    waitn(30);
    irq(1'b1);
    srst_i = 1'b1;
    waitn(2);
    irq(1'b0);
    chk("rdata", 8'h00, io_rdata_o);
    srst_i = 1'b0;
    rd(RA, 8'h00);
    irq(1'b0);
    waitn(30);
    rd(RA, 8'h80);
    rd(RB, 8'h00);
    irq(1'b0);
    $display("reset done");
  endtask : t_reset
  initial
  begin
    waitn(6);
    srst_i = 1'b0;
    t_idle();
    t_stall();
    t_clear();
    t_fan_b();
    t_reset();
    report_and_stop();
  end
  initial
  begin
    #50000;
    n_fail++;
    report_and_stop();
  end
endmodule : test_fan_stall_monitor
`default_nettype wire
